// ### src/ldc_regs.svh
// Contract
// RQ1: Bit 7 enables cluster string open/short faults
// RQ2: Bits 6:5 pick comparator hysteresis 1000-250 mV
// RQ3: Bits 4:3 pick short threshold 3.6/6.9/10.6 V
// RQ4: Bits 2:0 pick sink headroom, 111 smallest
// RQ5: Second register 7:5 set current slope gain
// RQ6: Bits 4:3 set PWM clock, internal oscillator only
// RQ7: Bits 2:0 set dither depth, 1XX four bits
// RQ8: Layout 111 puts all strings in cluster
// RQ9: Fields read back as written, no side effects
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

// Register offsets on the configuration port
`define LDC_OFS_FAULT_HEADROOM 8'h64
`define LDC_OFS_DIM_RES        8'h65

// Reset values of both configuration registers
`define LDC_RST_FAULT_HEADROOM 8'h00
`define LDC_RST_DIM_RES        8'h00

// Fault and headroom register field positions
`define LDC_CLF_BIT            7
`define LDC_HYST_MSB           6
`define LDC_HYST_LSB           5
`define LDC_THR_MSB            4
`define LDC_THR_LSB            3
`define LDC_HDR_MSB            2
`define LDC_HDR_LSB            0

// Dimming and resolution register field positions
`define LDC_SLOPE_MSB          7
`define LDC_SLOPE_LSB          5
`define LDC_PWMCLK_MSB         4
`define LDC_PWMCLK_LSB         3
`define LDC_DITH_MSB           2
`define LDC_DITH_LSB           0

// String layout code that puts every string in cluster mode
`define LDC_LAYOUT_ALL_CLUSTER 3'h7

`endif

// ### src/ldc_pkg.sv
package ldc_pkg;

	typedef logic [7:0]  ldc_byte_t;  // Register word
	typedef logic [9:0]  ldc_mv_t;    // Millivolts
	typedef logic [6:0]  ldc_dv_t;    // Tenths of a volt
	typedef logic [10:0] ldc_milli_t; // Gain in thousandths
	typedef logic [5:0]  ldc_mhz_t;   // Megahertz
	typedef logic [2:0]  ldc_bits_t;  // Dither bit count

	// Comparator hysteresis, falls with the code
	function automatic ldc_mv_t ldc_hyst_mv(input logic [1:0] code);
		unique case (code)
			2'h0: ldc_hyst_mv = 10'h3E8; // 1000 mV
			2'h1: ldc_hyst_mv = 10'h2EE; // 750 mV
			2'h2: ldc_hyst_mv = 10'h1F4; // 500 mV
			2'h3: ldc_hyst_mv = 10'h0FA; // 250 mV
		endcase
	endfunction

	// Short threshold, two lowest codes share one level
	function automatic ldc_dv_t ldc_short_dv(input logic [1:0] code);
		unique case (code)
			2'h0, 2'h1: ldc_short_dv = 7'h24; // 3.6 V
			2'h2:       ldc_short_dv = 7'h45; // 6.9 V
			2'h3:       ldc_short_dv = 7'h6A; // 10.6 V
		endcase
	endfunction

	// Headroom above saturation, largest at code zero
	function automatic ldc_mv_t ldc_headroom_mv(input logic [2:0] code);
		unique case (code)
			3'h7: ldc_headroom_mv = 10'h032; // 50 mV
			3'h6: ldc_headroom_mv = 10'h0AF; // 175 mV
			3'h5: ldc_headroom_mv = 10'h12C; // 300 mV
			3'h4: ldc_headroom_mv = 10'h1C2; // 450 mV
			3'h3: ldc_headroom_mv = 10'h23F; // 575 mV
			3'h2: ldc_headroom_mv = 10'h2BC; // 700 mV
			3'h1: ldc_headroom_mv = 10'h36B; // 875 mV
			3'h0: ldc_headroom_mv = 10'h3E8; // 1000 mV
		endcase
	endfunction

	// Current slope gain in thousandths
	function automatic ldc_milli_t ldc_slope_milli(input logic [2:0] code);
		unique case (code)
			3'h0: ldc_slope_milli = 11'h3E8; // 1.000
			3'h1: ldc_slope_milli = 11'h3FF; // 1.023
			3'h2: ldc_slope_milli = 11'h417; // 1.047
			3'h3: ldc_slope_milli = 11'h42E; // 1.070
			3'h4: ldc_slope_milli = 11'h446; // 1.094
			3'h5: ldc_slope_milli = 11'h45D; // 1.117
			3'h6: ldc_slope_milli = 11'h475; // 1.141
			3'h7: ldc_slope_milli = 11'h48C; // 1.164
		endcase
	endfunction

	// PWM generation clock, doubling per code
	function automatic ldc_mhz_t ldc_pwm_mhz(input logic [1:0] code);
		unique case (code)
			2'h0: ldc_pwm_mhz = 6'h05; // 5 MHz
			2'h1: ldc_pwm_mhz = 6'h0A; // 10 MHz
			2'h2: ldc_pwm_mhz = 6'h14; // 20 MHz
			2'h3: ldc_pwm_mhz = 6'h28; // 40 MHz
		endcase
	endfunction

	// Dither depth, any code with the top bit set saturates at four
	function automatic ldc_bits_t ldc_dither_bits(input logic [2:0] code);
		ldc_dither_bits = code[2] ? 3'h4 : code;
	endfunction

endpackage

// ### src/ldc_cfg_if.sv
`timescale 1ns/1ps
// Stored fields out to the decoder, decoded settings back
interface ldc_cfg_if;
	import ldc_pkg::*;
	ldc_byte_t  fault_cfg;            // Fault and headroom word
	ldc_byte_t  dim_cfg;              // Dimming and resolution word
	logic [2:0] string_layout_select; // Current string layout
	logic       frame_sync_used;      // PWM follows frame sync
	logic       cluster_fault_active; // Cluster faults armed
	ldc_mv_t    hyst_mv;              // Comparator hysteresis
	ldc_dv_t    short_dv;             // Short threshold
	ldc_mv_t    headroom_mv;          // Sink headroom
	ldc_milli_t slope_milli;          // Slope gain
	ldc_mhz_t   pwm_mhz;              // PWM clock, zero if not ours
	ldc_bits_t  dither_bits;          // Dither depth

	modport store (output fault_cfg, dim_cfg, string_layout_select, frame_sync_used,
		input cluster_fault_active, hyst_mv, short_dv, headroom_mv, slope_milli,
		pwm_mhz, dither_bits);
	modport decode (input fault_cfg, dim_cfg, string_layout_select, frame_sync_used,
		output cluster_fault_active, hyst_mv, short_dv, headroom_mv, slope_milli,
		pwm_mhz, dither_bits);
endinterface

// ### src/ldc_field_decode.sv
`timescale 1ns/1ps
`include "ldc_regs.svh"
// Turns stored codes into registered settings for the analog loops
module ldc_field_decode
	import ldc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	ldc_cfg_if.decode cfg
);

	// Cluster fault arming, only meaningful with all strings in cluster
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.cluster_fault_active <= 1'b0;
		end else begin
			cfg.cluster_fault_active <= cfg.fault_cfg[`LDC_CLF_BIT] &&
				(cfg.string_layout_select == `LDC_LAYOUT_ALL_CLUSTER); // [RQ1] [RQ8]
		end
	end

	// Boost loop and fault thresholds
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.hyst_mv     <= ldc_hyst_mv(2'h0);
			cfg.short_dv    <= ldc_short_dv(2'h0);
			cfg.headroom_mv <= ldc_headroom_mv(3'h0);
		end else begin
			cfg.hyst_mv     <= ldc_hyst_mv(cfg.fault_cfg[`LDC_HYST_MSB:`LDC_HYST_LSB]); // [RQ2]
			cfg.short_dv    <= ldc_short_dv(cfg.fault_cfg[`LDC_THR_MSB:`LDC_THR_LSB]); // [RQ3]
			cfg.headroom_mv <= ldc_headroom_mv(cfg.fault_cfg[`LDC_HDR_MSB:`LDC_HDR_LSB]); // [RQ4]
		end
	end

	// Dimming settings
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.slope_milli <= ldc_slope_milli(3'h0);
			cfg.pwm_mhz     <= 6'h00;
			cfg.dither_bits <= 3'h0;
		end else begin
			cfg.slope_milli <= ldc_slope_milli(cfg.dim_cfg[`LDC_SLOPE_MSB:`LDC_SLOPE_LSB]); // [RQ5]
			// Frame sync owns the PWM clock, so the field is ignored then
			cfg.pwm_mhz <= cfg.frame_sync_used ? 6'h00 :
				ldc_pwm_mhz(cfg.dim_cfg[`LDC_PWMCLK_MSB:`LDC_PWMCLK_LSB]); // [RQ6]
			cfg.dither_bits <= ldc_dither_bits(cfg.dim_cfg[`LDC_DITH_MSB:`LDC_DITH_LSB]); // [RQ7]
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_hyst_follows: assert property ( // [RQ2]
		##1 cfg.hyst_mv == ldc_hyst_mv($past(cfg.fault_cfg[`LDC_HYST_MSB:`LDC_HYST_LSB])))
		else $error("hysteresis does not follow its code");

	a_short_low_codes: assert property ( // [RQ3]
		(cfg.fault_cfg[`LDC_THR_MSB] == 1'b0) |=> (cfg.short_dv == 7'h24))
		else $error("low short codes not at 3.6 V");

	a_headroom_order: assert property ( // [RQ4]
		(cfg.fault_cfg[`LDC_HDR_MSB:`LDC_HDR_LSB] == 3'h7) |=> (cfg.headroom_mv == 10'h032))
		else $error("code 111 not smallest headroom");

	a_slope_follows: assert property ( // [RQ5]
		##1 cfg.slope_milli == ldc_slope_milli($past(cfg.dim_cfg[`LDC_SLOPE_MSB:`LDC_SLOPE_LSB])))
		else $error("slope gain does not follow its code");

endmodule

// ### src/ldc_nv_config.sv
`timescale 1ns/1ps
`include "ldc_regs.svh"
// Two stored configuration words for the LED driver, with decoded settings
module ldc_nv_config
	import ldc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	input  wire logic [2:0]  string_layout_select,
	input  wire logic        frame_sync_used,
	output logic             cluster_fault_enable,
	output logic      [1:0]  comparator_hysteresis_select,
	output logic      [1:0]  short_threshold_select,
	output logic      [2:0]  sink_headroom_select,
	output logic             cluster_fault_active,
	output logic      [9:0]  hysteresis_mv,
	output logic      [6:0]  short_threshold_dv,
	output logic      [9:0]  headroom_mv,
	output logic      [10:0] slope_gain_milli,
	output logic      [5:0]  pwm_clock_mhz,
	output logic      [2:0]  dither_bits
);

	ldc_byte_t fault_cfg_q; // Fault and headroom word
	ldc_byte_t dim_cfg_q;   // Dimming and resolution word
	ldc_byte_t rdata_q;     // Read data register
	logic      rvalid_q;    // Read answer marker

	ldc_cfg_if cfg_bus ();

	// Address match helpers
	logic hit_fault; // Access targets the fault word
	logic hit_dim;   // Access targets the dimming word
	assign hit_fault = (reg_addr == `LDC_OFS_FAULT_HEADROOM);
	assign hit_dim   = (reg_addr == `LDC_OFS_DIM_RES);

	// Fault and headroom word, written whole
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_cfg_q <= `LDC_RST_FAULT_HEADROOM;
		end else if (reg_wr && hit_fault) begin
			fault_cfg_q <= reg_wdata; // [RQ9]
		end
	end

	// Dimming and resolution word, written whole
	always_ff @(posedge clk) begin
		if (rst) begin
			dim_cfg_q <= `LDC_RST_DIM_RES;
		end else if (reg_wr && hit_dim) begin
			dim_cfg_q <= reg_wdata; // [RQ9]
		end
	end

	// Read path; a read only copies, so the stored words never move
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				// Unmapped offsets answer zero rather than stale data
				if (hit_fault) begin
					rdata_q <= fault_cfg_q; // [RQ9]
				end else if (hit_dim) begin
					rdata_q <= dim_cfg_q; // [RQ9]
				end else begin
					rdata_q <= 8'h00;
				end
			end
		end
	end

	// Stored words toward the decoder
	assign cfg_bus.fault_cfg            = fault_cfg_q;
	assign cfg_bus.dim_cfg              = dim_cfg_q;
	assign cfg_bus.string_layout_select = string_layout_select;
	assign cfg_bus.frame_sync_used      = frame_sync_used;

	// Decoded settings, registered inside the decoder
	ldc_field_decode u_decode (
		.clk (clk),
		.rst (rst),
		.cfg (cfg_bus.decode)
	);

	// Outputs, each taken straight from a flip-flop
	assign reg_rdata                    = rdata_q;
	assign reg_rvalid                   = rvalid_q;
	assign cluster_fault_enable         = fault_cfg_q[`LDC_CLF_BIT]; // [RQ1]
	assign comparator_hysteresis_select = fault_cfg_q[`LDC_HYST_MSB:`LDC_HYST_LSB];
	assign short_threshold_select       = fault_cfg_q[`LDC_THR_MSB:`LDC_THR_LSB];
	assign sink_headroom_select         = fault_cfg_q[`LDC_HDR_MSB:`LDC_HDR_LSB];
	assign cluster_fault_active         = cfg_bus.cluster_fault_active;
	assign hysteresis_mv                = cfg_bus.hyst_mv;
	assign short_threshold_dv           = cfg_bus.short_dv;
	assign headroom_mv                  = cfg_bus.headroom_mv;
	assign slope_gain_milli             = cfg_bus.slope_milli;
	assign pwm_clock_mhz                = cfg_bus.pwm_mhz;
	assign dither_bits                  = cfg_bus.dither_bits;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// A write followed at the very next edge by a read of the same word
	sequence s_wr_fault;
		reg_wr && hit_fault && !reg_rd;
	endsequence
	sequence s_rd_fault;
		reg_rd && hit_fault && !reg_wr;
	endsequence
	sequence s_wr_dim;
		reg_wr && hit_dim && !reg_rd;
	endsequence
	sequence s_rd_dim;
		reg_rd && hit_dim && !reg_wr;
	endsequence

	// Answer lands one edge after the read, carrying the data of the write before it
	a_fault_readback: assert property ( // [RQ9]
		s_wr_fault ##1 s_rd_fault |=> (reg_rvalid && reg_rdata == $past(reg_wdata, 2)))
		else $error("fault word read back differs");

	a_dim_readback: assert property ( // [RQ9]
		s_wr_dim ##1 s_rd_dim |=> (reg_rvalid && reg_rdata == $past(reg_wdata, 2)))
		else $error("dimming word read back differs");

	// Read and write in one cycle return the old word
	a_same_cycle_old: assert property ( // [RQ9]
		(reg_wr && reg_rd && hit_fault) |=> (reg_rdata == $past(fault_cfg_q)))
		else $error("same-cycle read did not return old word");

	a_dim_write: assert property ( // [RQ9]
		(reg_wr && hit_dim) |=> (dim_cfg_q == $past(reg_wdata)))
		else $error("dimming word not stored");

	a_read_no_effect: assert property ( // [RQ9]
		(reg_rd && !reg_wr) |=> ($stable(fault_cfg_q) && $stable(dim_cfg_q)))
		else $error("read changed a stored word");

	a_unmapped_zero: assert property (
		(reg_rd && !hit_fault && !hit_dim) |=> (reg_rvalid && reg_rdata == 8'h00))
		else $error("unmapped read not zero");

	a_cluster_arm: assert property ( // [RQ1] [RQ8]
		(fault_cfg_q[`LDC_CLF_BIT] && string_layout_select == `LDC_LAYOUT_ALL_CLUSTER)
			|=> cluster_fault_active)
		else $error("cluster faults not armed");

	a_cluster_off: assert property ( // [RQ1]
		!fault_cfg_q[`LDC_CLF_BIT] |=> !cluster_fault_active)
		else $error("cluster faults armed while disabled");

	a_pwm_gate: assert property ( // [RQ6]
		frame_sync_used |=> (pwm_clock_mhz == 6'h00))
		else $error("PWM clock set under frame sync");

	a_pwm_rate: assert property ( // [RQ6]
		(!frame_sync_used && dim_cfg_q[`LDC_PWMCLK_MSB:`LDC_PWMCLK_LSB] == 2'h3)
			|=> (pwm_clock_mhz == 6'h28))
		else $error("top PWM code not 40 MHz");

	a_dither_sat: assert property ( // [RQ7]
		dim_cfg_q[`LDC_DITH_MSB] |=> (dither_bits == 3'h4))
		else $error("dither 1XX not four bits");

	a_dither_low: assert property ( // [RQ7]
		!dim_cfg_q[`LDC_DITH_MSB] |=> (dither_bits == $past(dim_cfg_q[1:0])))
		else $error("dither depth wrong for low codes");

	a_hyst_stable: assert property ( // [RQ2]
		($stable(fault_cfg_q) [*2]) |-> $stable(hysteresis_mv))
		else $error("hysteresis moved without a write");

	// A stored word moves only on a write to its own offset
	a_fault_hold: assert property ( // [RQ9]
		!(reg_wr && hit_fault) |=> $stable(fault_cfg_q))
		else $error("fault word moved without a write");

	a_dim_hold: assert property ( // [RQ9]
		!(reg_wr && hit_dim) |=> $stable(dim_cfg_q))
		else $error("dimming word moved without a write");

	// Answer marker is a one-cycle pulse, data wait for the next read
	a_rvalid_pulse: assert property ( // [RQ9]
		!reg_rd |=> !reg_rvalid)
		else $error("read marker without a read");

	a_rdata_hold: assert property ( // [RQ9]
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");

	// Raw select outputs take the written fields one edge after the write
	a_enable_write: assert property ( // [RQ1]
		(reg_wr && hit_fault) |=> (cluster_fault_enable == $past(reg_wdata[`LDC_CLF_BIT])))
		else $error("cluster enable not taken from write");

	a_select_write: assert property ( // [RQ2] [RQ3] [RQ4]
		(reg_wr && hit_fault) |=>
			(comparator_hysteresis_select == $past(reg_wdata[`LDC_HYST_MSB:`LDC_HYST_LSB]) &&
			short_threshold_select == $past(reg_wdata[`LDC_THR_MSB:`LDC_THR_LSB]) &&
			sink_headroom_select == $past(reg_wdata[`LDC_HDR_MSB:`LDC_HDR_LSB])))
		else $error("select fields not taken from write");

	// One end point each of the short, headroom, slope, PWM and dither tables
	a_short_top: assert property ( // [RQ3]
		(fault_cfg_q[`LDC_THR_MSB:`LDC_THR_LSB] == 2'h3) |=> (short_threshold_dv == 7'h6A))
		else $error("short code 11 not at 10.6 V");

	a_headroom_max: assert property ( // [RQ4]
		(fault_cfg_q[`LDC_HDR_MSB:`LDC_HDR_LSB] == 3'h0) |=> (headroom_mv == 10'h3E8))
		else $error("headroom code 000 not largest");

	a_slope_top: assert property ( // [RQ5]
		(dim_cfg_q[`LDC_SLOPE_MSB:`LDC_SLOPE_LSB] == 3'h7) |=> (slope_gain_milli == 11'h48C))
		else $error("slope code 111 not at top gain");

	a_pwm_low: assert property ( // [RQ6]
		(!frame_sync_used && dim_cfg_q[`LDC_PWMCLK_MSB:`LDC_PWMCLK_LSB] == 2'h0)
			|=> (pwm_clock_mhz == 6'h05))
		else $error("PWM code 00 not 5 MHz");

	a_dither_off: assert property ( // [RQ7]
		(dim_cfg_q[`LDC_DITH_MSB:`LDC_DITH_LSB] == 3'h0) |=> (dither_bits == 3'h0))
		else $error("dither code 000 not off");

	// Any layout but all-cluster keeps cluster faults disarmed
	a_layout_gate: assert property ( // [RQ8]
		(string_layout_select != `LDC_LAYOUT_ALL_CLUSTER) |=> !cluster_fault_active)
		else $error("cluster faults armed outside cluster layout");

endmodule

// ### tb/ldc_host_model.sv
`timescale 1ns/1ps
// Host side of the strobe port: one whole word per access
module ldc_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// One-cycle write strobe, data held until the taking edge
	task automatic write_word(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d; // Stale data must not be reused
	endtask

	// Read answer taken one cycle after the strobe, then the marker must drop
	task automatic read_word(input logic [7:0] a, output logic [7:0] d,
		output logic v1, output logic v2);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
		v1 = reg_rvalid;
		@(posedge clk);
		#1;
		v2 = reg_rvalid;
	endtask

	// Write then read at the next edge, or both in the write's own cycle
	task automatic write_read(input logic [7:0] a, input logic [7:0] wd, input logic same,
		output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = wd;
		reg_wr = 1'b1;
		reg_rd = same;
		if (!same) begin
			@(posedge clk);
			#1;
			reg_wr = 1'b0;
			reg_rd = 1'b1;
		end
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
	import ldc_pkg::*;
	logic        clk, rst, reg_wr, reg_rd, reg_rvalid, fsync;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [2:0]  layout, c;
	logic        clf_en, cl_act;
	logic [1:0]  hy_sel, thr_sel;
	logic [2:0]  hdr_sel, dith;
	logic [9:0]  hy_mv, hdr_mv;
	logic [6:0]  sh_dv;
	logic [10:0] slope;
	logic [5:0]  pwm;
	logic [7:0]  rb;     // Word seen by a back to back read
	int          error_cnt = 0;
	int          n_checks = 0;
	// Expected settings per code
	logic [9:0]  hy_tab [4] = '{10'h3E8, 10'h2EE, 10'h1F4, 10'h0FA};
	logic [6:0]  sh_tab [4] = '{7'h24, 7'h24, 7'h45, 7'h6A};
	logic [9:0]  hd_tab [8] = '{10'h3E8, 10'h36B, 10'h2BC, 10'h23F,
		10'h1C2, 10'h12C, 10'h0AF, 10'h032};
	logic [10:0] sl_tab [8] = '{11'h3E8, 11'h3FF, 11'h417, 11'h42E,
		11'h446, 11'h45D, 11'h475, 11'h48C};
	logic [5:0]  pw_tab [4] = '{6'h05, 6'h0A, 6'h14, 6'h28};

	ldc_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	ldc_nv_config u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .string_layout_select(layout),
		.frame_sync_used(fsync), .cluster_fault_enable(clf_en),
		.comparator_hysteresis_select(hy_sel), .short_threshold_select(thr_sel),
		.sink_headroom_select(hdr_sel), .cluster_fault_active(cl_act),
		.hysteresis_mv(hy_mv), .short_threshold_dv(sh_dv), .headroom_mv(hdr_mv),
		.slope_gain_milli(slope), .pwm_clock_mhz(pwm), .dither_bits(dith));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Case inequality so an unknown never matches
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s exp=%0h seen=%0h", nm, exp, seen);
		end
	endtask

	// Read one word, check data, marker and its one-cycle width
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v1, v2;
		u_host.read_word(a, d, v1, v2);
		chk("rdata", d, e);
		chk("rvalid", v1, 1'b1);
		chk("rvalid_drop", v2, 1'b0);
	endtask

	// Outputs just after reset drops, before any edge has decoded anything
	task automatic reset_chk;
		chk("rst_clf_en", clf_en, 1'b0);
		chk("rst_sel", {hy_sel, thr_sel, hdr_sel}, 7'h00);
		chk("rst_hy_mv", hy_mv, hy_tab[0]);
		chk("rst_sh_dv", sh_dv, sh_tab[0]);
		chk("rst_hdr_mv", hdr_mv, hd_tab[0]);
		chk("rst_slope", slope, sl_tab[0]);
		chk("rst_pwm", pwm, 6'h00);
		chk("rst_dither", dith, 3'h0);
		chk("rst_cl_act", cl_act, 1'b0);
		chk("rst_read", {reg_rvalid, reg_rdata}, 9'h000);
	endtask

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, far beyond the roughly 145 cycles needed
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		final_report;
	end

	// Main sequence
	initial begin
		fsync = 1'b0;
		layout = 3'h0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		reset_chk;
		rd_chk(8'h64, 8'h00);
		rd_chk(8'h65, 8'h00);
		$display("test reset done");
		// Every code of every field; layout sweeps too
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			layout = c;
			u_host.write_word(8'h64, {c[0], c[1:0], c[1:0], c});
			u_host.write_word(8'h65, {c, c[1:0], c});
			repeat (2) @(posedge clk);
			#1;
			chk("clf_en", clf_en, c[0]);
			chk("hy_sel", hy_sel, c[1:0]);
			chk("hy_mv", hy_mv, hy_tab[c[1:0]]);
			chk("thr_sel", thr_sel, c[1:0]);
			chk("sh_dv", sh_dv, sh_tab[c[1:0]]);
			chk("hdr_sel", hdr_sel, c);
			chk("hdr_mv", hdr_mv, hd_tab[c]);
			chk("slope", slope, sl_tab[c]);
			chk("pwm", pwm, pw_tab[c[1:0]]);
			chk("dither", dith, c[2] ? 3'h4 : c);
			chk("cl_act", cl_act, c == 3'h7);
			rd_chk(8'h64, {c[0], c[1:0], c[1:0], c});
			rd_chk(8'h65, {c, c[1:0], c});
		end
		$display("test code sweep done");
		// Frame sync owns the clock; cluster enable off with all-cluster layout
		fsync = 1'b1;
		u_host.write_word(8'h64, 8'h7F);
		repeat (2) @(posedge clk);
		#1;
		chk("pwm_fsync", pwm, 6'h00);
		chk("cl_act_off", cl_act, 1'b0);
		$display("test frame sync done");
		// Unmapped offset: write ignored, read gives zero; reads repeat cleanly
		u_host.write_word(8'h66, 8'hA5);
		rd_chk(8'h66, 8'h00);
		rd_chk(8'h64, 8'h7F);
		rd_chk(8'h65, 8'hFF);
		rd_chk(8'h65, 8'hFF);
		$display("test unmapped done");
		// Back to back write and read of each word, then a read in the write's cycle
		u_host.write_read(8'h64, 8'h5A, 1'b0, rb);
		chk("wr_rd_fault", rb, 8'h5A);
		u_host.write_read(8'h65, 8'h3C, 1'b0, rb);
		chk("wr_rd_dim", rb, 8'h3C);
		u_host.write_read(8'h64, 8'hC3, 1'b1, rb);
		chk("same_cycle_old", rb, 8'h5A);
		rd_chk(8'h64, 8'hC3);
		chk("cl_act_on", cl_act, 1'b1);
		chk("hdr_mv_c3", hdr_mv, hd_tab[3]);
		$display("test back to back done");
		// Reset again in mid-run: words and decoded settings return to reset
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		reset_chk;
		rd_chk(8'h64, 8'h00);
		rd_chk(8'h65, 8'h00);
		$display("test mid reset done");
		final_report;
	end
endmodule
